// >>> common/eil_pkg.sv
// Package for the external interrupt latch: register map, field layout, reset values.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package eil_pkg;
    localparam int ADDR_W = 4;
    // Register byte offsets
    localparam logic [3:0] OFF_STATUS_CTRL = 4'h0;
    localparam logic [3:0] OFF_EVT_STATUS = 4'h4;
    localparam logic [3:0] OFF_EVT_MASK = 4'h8;
    // ext_int_status_ctrl field positions
    localparam int BIT_MODE = 0;
    localparam int BIT_BLOCK = 1;
    localparam int BIT_ACK = 2;
    localparam int BIT_PEND = 3;
    localparam int BIT_PIN = 4;
    // Event status fields
    localparam int EVT_LATCH = 0;
    localparam int EVT_ACK = 1;
    localparam int EVT_W = 2;
    // Reset values
    localparam logic RST_MODE = 1'b0;
    localparam logic RST_BLOCK = 1'b0;
    localparam logic [1:0] RST_EVT = 2'h0;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    // Synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage

// >>> rtl/eil_pin_sync.sv
// Two-stage synchroniser and falling edge detector for the interrupt pin.
// Assumes pin is asynchronous to clk; idles high.
`timescale 1ns/1ps
`default_nettype none
module eil_pin_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin_n,
    output logic pin_s,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;
    logic [2:0] fill_r;

    // Reset to the idle level; fill_r holds off edges until prev_r holds a real sample
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
            fill_r <= 3'h0;
        end else begin
            meta_r <= pin_n;
            sync_r <= meta_r;
            prev_r <= sync_r;
            fill_r <= {fill_r[1:0], 1'b1};
        end
    end

    assign pin_s = sync_r;
    // A pin held low through reset is not a falling edge
    assign fall = fill_r[2] & prev_r & ~sync_r;

    a_fall_shape: assert property (@(posedge clk) disable iff (!rstn)
        fall |-> ($past(sync_r) && !sync_r))
        else $error("fall without high then low sample");
endmodule // eil_pin_sync
`default_nettype wire

// >>> rtl/eil_avmm_slave.sv
// Avalon-MM slave front end: one wait state, then a one-cycle access strobe.
// Assumes master holds the request until waitrequest is low.
`timescale 1ns/1ps
`default_nettype none
module eil_avmm_slave (
    input wire logic clk,
    input wire logic rstn,
    input wire logic read,
    input wire logic write,
    output logic waitrequest,
    output logic rd_go,
    output logic wr_go
);
    logic done_r;

    // Access completes on the second cycle of each request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (read | write) & ~done_r;
        end
    end

    assign waitrequest = (read | write) & ~done_r;
    assign rd_go = read & done_r;
    assign wr_go = write & done_r;
endmodule // eil_avmm_slave
`default_nettype wire

// >>> rtl/eil_top.sv
// External interrupt latch with Avalon-MM registers and event interrupt.
// Assumes one clock; pin asynchronous; vector fetch strobe from the CPU on clk.
`timescale 1ns/1ps
`default_nettype none
module eil_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_int_n,
    input wire logic vector_fetch,
    output logic cpu_irq,
    output logic evt_irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic pin_s;
    logic fall;
    logic rd_go;
    logic wr_go;
    logic mode_r;
    logic block_r;
    logic latch_r;
    logic ack_seen_r;
    logic [1:0] evt_r;
    logic [1:0] evt_mask_r;
    logic [31:0] rdata_r;
    logic cpu_irq_r;
    logic evt_irq_r;
    logic sw_ack;
    logic any_ack;
    logic set_req;
    logic wr_ctrl;

    eil_pin_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_n(ext_int_n),
        .pin_s(pin_s),
        .fall(fall)
    );

    eil_avmm_slave u_bus (
        .clk(clk),
        .rstn(rstn),
        .read(avs_read),
        .write(avs_write),
        .waitrequest(avs_waitrequest),
        .rd_go(rd_go),
        .wr_go(wr_go)
    );

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign wr_ctrl = wr_go & hit(avs_address, eil_pkg::OFF_STATUS_CTRL);
    assign sw_ack = wr_ctrl & avs_writedata[eil_pkg::BIT_ACK];
    assign any_ack = sw_ack | vector_fetch;
    // Level mode keeps asserting while the pin stays low
    assign set_req = fall | (mode_r & ~pin_s);

    // Control bits; reset values give edge-only, unblocked
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= eil_pkg::RST_MODE;
            block_r <= eil_pkg::RST_BLOCK;
        end else if (wr_ctrl) begin
            mode_r <= avs_writedata[eil_pkg::BIT_MODE];
            block_r <= avs_writedata[eil_pkg::BIT_BLOCK];
        end
    end

    // Request latch; a new edge wins over a simultaneous acknowledge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latch_r <= 1'b0;
            ack_seen_r <= 1'b0;
        end else if (set_req & ~(any_ack & ~fall)) begin
            latch_r <= 1'b1;
            // Low level keeps the latch set but must not forget an earlier acknowledge
            ack_seen_r <= mode_r & ack_seen_r & ~fall;
        end else if (!mode_r) begin
            ack_seen_r <= 1'b0;
            if (any_ack) begin
                latch_r <= 1'b0;
            end
        end else begin
            // Level mode: acknowledge remembered until pin returns high
            if (latch_r && (any_ack || ack_seen_r) && pin_s) begin
                latch_r <= 1'b0;
                ack_seen_r <= 1'b0;
            end else if (latch_r && any_ack) begin
                ack_seen_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events: latch set, acknowledge; write one to clear, set wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_r <= eil_pkg::RST_EVT;
        end else begin
            for (int i = 0; i < eil_pkg::EVT_W; i++) begin
                if ((i == eil_pkg::EVT_LATCH && set_req && !latch_r) ||
                    (i == eil_pkg::EVT_ACK && any_ack)) begin
                    evt_r[i] <= 1'b1;
                end else if (wr_go && hit(avs_address, eil_pkg::OFF_EVT_STATUS)
                             && avs_writedata[i]) begin
                    evt_r[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_mask_r <= eil_pkg::RST_EVT;
        end else if (wr_go && hit(avs_address, eil_pkg::OFF_EVT_MASK)) begin
            evt_mask_r <= avs_writedata[1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_irq_r <= 1'b0;
            evt_irq_r <= 1'b0;
        end else begin
            cpu_irq_r <= latch_r & ~block_r;
            evt_irq_r <= |(evt_r & evt_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data registered; acknowledge bit always reads zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            if (hit(avs_address, eil_pkg::OFF_STATUS_CTRL)) begin
                rdata_r <= {27'h0000000, pin_s, latch_r, 1'b0, block_r, mode_r};
            end else if (hit(avs_address, eil_pkg::OFF_EVT_STATUS)) begin
                rdata_r <= {30'h00000000, evt_r};
            end else if (hit(avs_address, eil_pkg::OFF_EVT_MASK)) begin
                rdata_r <= {30'h00000000, evt_mask_r};
            end else begin
                rdata_r <= eil_pkg::RD_UNMAPPED;
            end
        end
    end

    assign avs_readdata = rdata_r;
    assign cpu_irq = cpu_irq_r;
    assign evt_irq = evt_irq_r;

    ////////////////////////////////////////////////////////////////////////////
    a_reset_clear: assert property (@(posedge clk) $rose(rstn) |-> !latch_r)
        else $error("latch not clear after reset");
    a_edge_sets: assert property (@(posedge clk) disable iff (!rstn)
        (fall && !any_ack) |=> latch_r)
        else $error("edge did not set latch");
    a_vec_clears: assert property (@(posedge clk) disable iff (!rstn)
        (vector_fetch && !mode_r && !set_req) |=> !latch_r)
        else $error("vector fetch did not clear latch");
    a_sw_ack_clears: assert property (@(posedge clk) disable iff (!rstn)
        (sw_ack && !mode_r && !set_req) |=> !latch_r)
        else $error("software acknowledge did not clear latch");
    a_edge_holds: assert property (@(posedge clk) disable iff (!rstn)
        (latch_r && !mode_r && !any_ack) |=> latch_r)
        else $error("edge-mode latch dropped without acknowledge");
    a_level_holds: assert property (@(posedge clk) disable iff (!rstn)
        (mode_r && latch_r && !pin_s) |=> latch_r)
        else $error("level-mode latch cleared while pin low");
    a_block_gates: assert property (@(posedge clk) disable iff (!rstn)
        cpu_irq |-> $past(latch_r && !block_r))
        else $error("request forwarded while blocked");
    a_edge_default: assert property (@(posedge clk) $rose(rstn) |-> !mode_r)
        else $error("mode not edge-only after reset");
    a_pend_read: assert property (@(posedge clk) disable iff (!rstn)
        (avs_read && avs_waitrequest && avs_address == eil_pkg::OFF_STATUS_CTRL)
        |=> (avs_readdata[eil_pkg::BIT_PEND] == $past(latch_r)
             && !avs_readdata[eil_pkg::BIT_ACK]))
        else $error("pending flag or ack readback wrong");
    c_edge_ack: cover property (@(posedge clk) disable iff (!rstn)
        fall ##[1:20] (vector_fetch && latch_r));
    c_level_mode: cover property (@(posedge clk) disable iff (!rstn)
        (mode_r && latch_r && sw_ack && !pin_s) ##[1:50] !latch_r);
    c_blocked: cover property (@(posedge clk) disable iff (!rstn) latch_r && block_r);
endmodule // eil_top
`default_nettype wire

// >>> verification/eil_irq_source.sv
// Model of the off-chip source that drives the active-low interrupt pin.
// Assumes the pin has a pull-up, so a released pin reads high.
`timescale 1ns/1ps
`default_nettype none
module eil_irq_source (
    input wire logic clk,
    output logic ext_int_n
);
    // Pull-up level until the source first pulls the pin
    initial ext_int_n = 1'h1;
    task automatic drive(input logic lvl);
        @(posedge clk);
        ext_int_n <= lvl;
    endtask
    // Short low pulse, then released back to the pull-up level
    task automatic pulse(input int n);
        drive(1'h0);
        repeat (n) @(posedge clk);
        ext_int_n <= 1'h1;
    endtask
endmodule // eil_irq_source
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for eil_top: reads are checked against a queue of expectations.
// Assumes the pin source model eil_irq_source.
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    localparam logic [3:0] SC = eil_pkg::OFF_STATUS_CTRL;
    localparam logic [3:0] ST = eil_pkg::OFF_EVT_STATUS;
    localparam logic [3:0] MK = eil_pkg::OFF_EVT_MASK;
    logic clk, rstn, avs_read, avs_write, avs_waitrequest, ext_int_n, vector_fetch;
    logic cpu_irq, evt_irq;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rnd;
    logic [33:0] exp_q[$];
    logic [33:0] e_v;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    eil_top dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_int_n(ext_int_n),
        .vector_fetch(vector_fetch), .cpu_irq(cpu_irq), .evt_irq(evt_irq));
    eil_irq_source src (.clk(clk), .ext_int_n(ext_int_n));
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [33:0] ex(input logic c, input logic v, input logic [31:0] d);
        return {c, v, d};
    endfunction
    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            close_out;
        end
    end
    // Both irq lines are checked with each read so masking is seen at the outputs
    always @(posedge clk) begin
        if (avs_read === 1'h1 && avs_waitrequest === 1'h0) begin
            e_v = exp_q.pop_front();
            `CMP({cpu_irq, evt_irq, avs_readdata}, e_v)
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Request held until the rising edge that sees waitrequest low
    task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'h0);
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        acc(a, 1'h1, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        acc(a, 1'h0, 32'h0);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic vfetch;
        vector_fetch <= 1'h1;
        @(posedge clk);
        vector_fetch <= 1'h0;
        idle(3);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'h0;
        avs_address = 4'h0;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0;
        vector_fetch = 1'h0;
        rnd = 32'hA6A0;
        idle(20);
        rstn <= 1'h1;
        idle(1);
        rd(SC, ex(1'h0, 1'h0, 32'h10));
        rd(ST, ex(1'h0, 1'h0, 32'h0));
        rd(MK, ex(1'h0, 1'h0, 32'h0));
        rd(4'hC, ex(1'h0, 1'h0, 32'h0));
        src.drive(1'h0);
        idle(8);
        rd(SC, ex(1'h1, 1'h0, 32'h8));
        vfetch;
        rd(SC, ex(1'h0, 1'h0, 32'h0));
        idle(8);
        rd(SC, ex(1'h0, 1'h0, 32'h0));
        src.drive(1'h1);
        src.pulse(2);
        idle(8);
        rd(SC, ex(1'h1, 1'h0, 32'h18));
        wr(SC, 32'h2);
        idle(3);
        rd(SC, ex(1'h0, 1'h0, 32'h1A));
        wr(SC, 32'h6);
        idle(3);
        rd(SC, ex(1'h0, 1'h0, 32'h12));
        wr(SC, 32'h1);
        src.drive(1'h0);
        idle(8);
        rd(SC, ex(1'h1, 1'h0, 32'h9));
        wr(SC, 32'h5);
        idle(8);
        rd(SC, ex(1'h1, 1'h0, 32'h9));
        src.drive(1'h1);
        idle(8);
        rd(SC, ex(1'h0, 1'h0, 32'h11));
        src.pulse(3);
        idle(8);
        rd(SC, ex(1'h1, 1'h0, 32'h19));
        vfetch;
        rd(SC, ex(1'h0, 1'h0, 32'h11));
        wr(MK, 32'h3);
        idle(2);
        rd(ST, ex(1'h0, 1'h1, 32'h3));
        wr(ST, 32'h1);
        idle(2);
        rd(ST, ex(1'h0, 1'h1, 32'h2));
        wr(ST, 32'h2);
        idle(2);
        rd(MK, ex(1'h0, 1'h0, 32'h3));
        wr(MK, 32'h0);
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            wr(SC, rnd);
            rd(SC, ex(1'h0, 1'h0, {27'h0, 3'h4, rnd[1:0]}));
        end
        wr(SC, 32'h3);
        src.drive(1'h0);
        idle(8);
        rstn <= 1'h0;
        idle(2);
        rstn <= 1'h1;
        idle(4);
        rd(SC, ex(1'h0, 1'h0, 32'h0));
        src.drive(1'h1);
        idle(4);
        close_out;
    end
endmodule // testbench
`default_nettype wire
